// *** hdl/mld_cfg.svh ***
// constants of the memory display control block
`ifndef MLD_CFG_SVH
`define MLD_CFG_SVH
// ****************************************************************
// panel geometry
// ****************************************************************
`define MLD_COLS 8'h90
`define MLD_ROWS 8'ha8
`define MLD_FIRST_ROW 8'h01
`define MLD_PIX_WHITE 1'b1
// ****************************************************************
// serial frame layout
// ****************************************************************
`define MLD_MODE_BITS 8'h08
`define MLD_ADDR_BITS 8'h08
`define MLD_DUMMY_BITS 8'h08
`define MLD_MODE_UPDATE 0
`define MLD_MODE_COM 1
`define MLD_MODE_CLEAR 2
`define MLD_FIFO_DEPTH 8
// ****************************************************************
// register map
// ****************************************************************
`define MLD_REG_STATUS 8'h00
`define MLD_REG_CTRL 8'h04
`define MLD_ST_STRAP 0
`define MLD_ST_DISPLAY_ON_INPUT 1
`define MLD_ST_POL 2
`define MLD_ST_BUSY 3
`define MLD_ST_OVF 4
`define MLD_ST_BADADDR 5
`define MLD_ST_LEVEL 8
`define MLD_CTRL_LINK_EN 0
`define MLD_CTRL_RESET 1'b1
`endif

// *** hdl/mld_pkg.sv ***
// types shared by the memory display control block
package mld_pkg;
`include "mld_cfg.svh"
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_MODE  = 5'h02,
      ST_ADDR  = 5'h04,
      ST_DATA  = 5'h08,
      ST_DUMMY = 5'h10
   } mld_state_t;
   typedef logic [`MLD_COLS-1:0] mld_row_t;
   typedef logic [7:0] mld_addr_t;
endpackage : mld_pkg

// *** hdl/mld_fifo.sv ***
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module mld_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic wr_valid_i, // push request
   output logic wr_ready_o, // room left
   input wire logic [WIDTH-1:0] wr_data_i, // push data
   output logic rd_valid_o, // data waiting
   input wire logic rd_ready_i, // drain side accepts
   output logic [WIDTH-1:0] rd_data_o, // head word
   output logic [$clog2(DEPTH):0] count_o // words held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   wire do_wr;
   wire do_rd;
   // ****************************************************************
   // flags from pointers, extra bit tells full from empty
   // ****************************************************************
   assign count_o = wr_ptr_q - rd_ptr_q;
   assign wr_ready_o = (count_o != DEPTH[AW:0]);
   assign rd_valid_o = (count_o != '0);
   assign do_wr = wr_valid_i & wr_ready_o;
   assign do_rd = rd_valid_o & rd_ready_i;
   assign rd_data_o = mem_q[rd_ptr_q[AW-1:0]];
   // pointer update
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (do_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
         if (do_rd) rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end
   // storage, no reset needed: read only behind the pointers
   always_ff @(posedge clk_i) begin
      if (do_wr) mem_q[wr_ptr_q[AW-1:0]] <= wr_data_i;
   end
endmodule : mld_fifo

// *** hdl/mld_display_ctrl.sv ***
// memory display control front end: serial link, pixel store, scan
`timescale 1ns/1ns
`include "mld_cfg.svh"
// Behaviour
// - strap high: external toggle flips polarity
// - strap low: polarity from serial flag
// - display on: show pixel memory contents
// - display off: white out, memory kept
// - memory is 144 columns by 168 rows
// - one stored bit per pixel, kept
// - single addressed line rewritten alone
module mld_display_ctrl (
   input wire logic CLK_I, // 50 MHz clock
   input wire logic RST_N_I, // sync reset, active low
   input wire logic SERIAL_CLK_I, // link clock pin
   input wire logic SERIAL_DATA_I, // link data pin
   input wire logic CHIP_SELECT_IN_I, // frame select, high
   input wire logic EXTERNAL_INVERSION_TOGGLE_I, // toggle pin
   input wire logic DISPLAY_ON_INPUT_I, // high shows memory
   input wire logic INVERSION_SOURCE_STRAP_I, // polarity source
   input wire logic [7:0] REG_ADDR_I, // register byte address
   input wire logic [31:0] REG_WDATA_I, // write data
   input wire logic REG_WR_I, // write strobe
   input wire logic REG_RD_I, // read strobe
   output logic [31:0] REG_RDATA_O, // read data, next cycle
   input wire mld_pkg::mld_addr_t SCAN_ROW_I, // row index to show
   output mld_pkg::mld_row_t SCAN_DATA_O, // shown row, 1 white
   output logic COM_POLARITY_O // common electrode polarity
);
   import mld_pkg::*;
   localparam int NSYNC = 5;
   localparam int IX_SCLK = 0;
   localparam int IX_SI = 1;
   localparam int IX_CS = 2;
   localparam int IX_TGL = 3;
   localparam int IX_DISPLAY_ON_INPUT = 4;
   localparam int LW = $clog2(`MLD_FIFO_DEPTH) + 1;

   // rising edge of a synchronised level
   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] dly_q;
   logic strap1_q;
   logic strap2_q;
   wire [NSYNC-1:0] pins_in = {DISPLAY_ON_INPUT_I,
      EXTERNAL_INVERSION_TOGGLE_I, CHIP_SELECT_IN_I, SERIAL_DATA_I,
      SERIAL_CLK_I};

   // two flops per pin, third stage only for edge finding
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         sync1_q <= '0;
         sync2_q <= '0;
         dly_q <= '0;
         strap1_q <= 1'b0;
         strap2_q <= 1'b0;
      end else begin
         sync1_q <= pins_in;
         sync2_q <= sync1_q;
         dly_q <= sync2_q;
         strap1_q <= INVERSION_SOURCE_STRAP_I;
         strap2_q <= strap1_q;
      end
   end

   // ****************************************************************
   // serial deserialiser
   // ****************************************************************
   mld_state_t state_q;
   mld_state_t state_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] mode_q;
   mld_addr_t addr_q;
   mld_row_t row_q;
   logic com_flag_q;
   logic clear_req_q;
   logic push_q;
   logic link_en_q;
   logic [7:0] last_cnt;

   wire cs_lvl = sync2_q[IX_CS];
   wire si_now = sync2_q[IX_SI];
   wire bit_tick = link_en_q & cs_lvl &
      rise(sync2_q[IX_SCLK], dly_q[IX_SCLK]);
   wire cs_rise = rise(cs_lvl, dly_q[IX_CS]);
   wire field_end = bit_tick & (cnt_q == last_cnt);

   // length of the field being shifted in
   always_comb begin
      case (state_q)
         ST_MODE: last_cnt = `MLD_MODE_BITS - 8'h01;
         ST_ADDR: last_cnt = `MLD_ADDR_BITS - 8'h01;
         ST_DATA: last_cnt = `MLD_COLS - 8'h01;
         ST_DUMMY: last_cnt = `MLD_DUMMY_BITS - 8'h01;
         default: last_cnt = 8'hff;
      endcase
   end

   // frame sequencing; dropping select aborts the frame anywhere
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cs_rise && link_en_q) state_d = ST_MODE;
         end
         ST_MODE: begin
            if (field_end) begin
               state_d = mode_q[`MLD_MODE_UPDATE] ? ST_ADDR : ST_DUMMY;
            end
         end
         ST_ADDR: begin
            if (field_end) state_d = ST_DATA;
         end
         ST_DATA: begin
            if (field_end) state_d = ST_DUMMY;
         end
         ST_DUMMY: begin
            if (field_end && mode_q[`MLD_MODE_UPDATE]) begin
               state_d = ST_ADDR; // next line of the same frame
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (!cs_lvl || !link_en_q) state_d = ST_IDLE;
   end

   // bit counter restarts with each field
   assign cnt_d = (state_d != state_q) ? 8'h00 :
      (bit_tick ? cnt_q + 8'h01 : cnt_q);

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // field capture, first bit on the wire is bit 0
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         mode_q <= 8'h00;
         addr_q <= '0;
         row_q <= '0;
      end else if (bit_tick) begin
         case (state_q)
            ST_MODE: mode_q[cnt_q[2:0]] <= si_now;
            ST_ADDR: addr_q[cnt_q[2:0]] <= si_now;
            ST_DATA: row_q[cnt_q] <= si_now;
            default: ;
         endcase
      end
   end

   // mode byte effects and line hand-off
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         com_flag_q <= 1'b0;
         clear_req_q <= 1'b0;
         push_q <= 1'b0;
      end else begin
         clear_req_q <= 1'b0;
         if (field_end && state_q == ST_MODE) begin
            com_flag_q <= mode_q[`MLD_MODE_COM];
            clear_req_q <= mode_q[`MLD_MODE_CLEAR];
         end
         // one cycle late so the last pixel bit is already stored
         push_q <= field_end && (state_q == ST_DATA);
      end
   end

   // ****************************************************************
   // line buffer between link and pixel store
   // ****************************************************************
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [LW-1:0] fifo_level;
   logic [`MLD_COLS+7:0] fifo_head;

   mld_fifo #(
      .WIDTH(`MLD_COLS + 8),
      .DEPTH(`MLD_FIFO_DEPTH)
   ) u_line_fifo (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .wr_valid_i(push_q),
      .wr_ready_o(fifo_wr_ready),
      .wr_data_i({addr_q, row_q}),
      .rd_valid_o(fifo_rd_valid),
      .rd_ready_i(fifo_rd_ready),
      .rd_data_o(fifo_head),
      .count_o(fifo_level)
   );

   // ****************************************************************
   // pixel store and all-clear walker
   // ****************************************************************
   mld_row_t mem_q [0:`MLD_ROWS-1];
   logic clear_busy_q;
   mld_addr_t clr_row_q;

   wire mld_addr_t head_addr = fifo_head[`MLD_COLS+7:`MLD_COLS];
   wire mld_row_t head_row = fifo_head[`MLD_COLS-1:0];
   // the walker stalls the drain, lines queue up behind it
   assign fifo_rd_ready = ~clear_busy_q;
   wire pop = fifo_rd_valid & fifo_rd_ready;
   wire addr_ok = (head_addr >= `MLD_FIRST_ROW) &&
      (head_addr <= `MLD_ROWS);
   wire mld_addr_t wr_idx = head_addr - `MLD_FIRST_ROW;
   wire line_wr = pop & addr_ok;
   wire bad_line = pop & ~addr_ok;
   wire overflow = push_q & ~fifo_wr_ready;

   // walker runs one row per cycle until all rows are white
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         clear_busy_q <= 1'b0;
         clr_row_q <= '0;
      end else if (clear_busy_q) begin
         clr_row_q <= clr_row_q + 8'h01;
         if (clr_row_q == `MLD_ROWS - 8'h01) clear_busy_q <= 1'b0;
      end else if (clear_req_q) begin
         clear_busy_q <= 1'b1;
         clr_row_q <= '0;
      end
   end

   // pixel rows, no reset: contents survive display off
   always_ff @(posedge CLK_I) begin
      if (clear_busy_q) begin
         mem_q[clr_row_q] <= {`MLD_COLS{`MLD_PIX_WHITE}};
      end else if (line_wr) begin
         mem_q[wr_idx] <= head_row;
      end
   end

   // ****************************************************************
   // panel scan output and polarity
   // ****************************************************************
   logic pol_q;
   mld_row_t scan_q;
   wire display_on_input_on = sync2_q[IX_DISPLAY_ON_INPUT];
   wire scan_ok = (SCAN_ROW_I < `MLD_ROWS);

   // blanking only masks the output, the store is untouched
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         scan_q <= {`MLD_COLS{`MLD_PIX_WHITE}};
      end else if (display_on_input_on && scan_ok) begin
         scan_q <= mem_q[SCAN_ROW_I];
      end else begin
         scan_q <= {`MLD_COLS{`MLD_PIX_WHITE}};
      end
   end

   // strap picks the inversion source; followed live, it is tied
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         pol_q <= 1'b0;
      end else if (strap2_q) begin
         if (rise(sync2_q[IX_TGL], dly_q[IX_TGL])) begin
            pol_q <= ~pol_q;
         end
      end else begin
         pol_q <= com_flag_q;
      end
   end

   assign SCAN_DATA_O = scan_q;
   assign COM_POLARITY_O = pol_q;

   // ****************************************************************
   // register port
   // ****************************************************************
   logic ovf_q;
   logic bad_q;
   logic [31:0] rdata_q;
   logic [31:0] status_word;
   wire sel_status = (REG_ADDR_I == `MLD_REG_STATUS);
   wire sel_ctrl = (REG_ADDR_I == `MLD_REG_CTRL);
   wire clr_ovf = REG_WR_I & sel_status & REG_WDATA_I[`MLD_ST_OVF];
   wire clr_bad = REG_WR_I & sel_status & REG_WDATA_I[`MLD_ST_BADADDR];

   // live state plus sticky error flags
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`MLD_ST_STRAP] = strap2_q;
      status_word[`MLD_ST_DISPLAY_ON_INPUT] = display_on_input_on;
      status_word[`MLD_ST_POL] = pol_q;
      status_word[`MLD_ST_BUSY] = clear_busy_q;
      status_word[`MLD_ST_OVF] = ovf_q;
      status_word[`MLD_ST_BADADDR] = bad_q;
      status_word[`MLD_ST_LEVEL +: LW] = fifo_level;
   end

   // sticky flags: a new event beats a clear in the same cycle
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ovf_q <= 1'b0;
         bad_q <= 1'b0;
         link_en_q <= `MLD_CTRL_RESET;
      end else begin
         ovf_q <= overflow | (ovf_q & ~clr_ovf);
         bad_q <= bad_line | (bad_q & ~clr_bad);
         if (REG_WR_I && sel_ctrl) begin
            link_en_q <= REG_WDATA_I[`MLD_CTRL_LINK_EN];
         end
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rdata_q <= 32'h0000_0000;
      end else if (REG_RD_I && sel_status) begin
         rdata_q <= status_word;
      end else if (REG_RD_I && sel_ctrl) begin
         rdata_q <= {31'h0000_0000, link_en_q};
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign REG_RDATA_O = rdata_q;
endmodule : mld_display_ctrl

// *** bench/mld_ctrl_properties.sv ***
// port level checks of the memory display control block
`timescale 1ns/1ns
module mld_ctrl_checker (
   input wire logic CLK_I, // clock
   input wire logic RST_N_I, // reset, low
   input wire logic SERIAL_CLK_I, // link clock
   input wire logic SERIAL_DATA_I, // link data
   input wire logic CHIP_SELECT_IN_I, // frame select
   input wire logic EXTERNAL_INVERSION_TOGGLE_I, // toggle pin
   input wire logic DISPLAY_ON_INPUT_I, // display on
   input wire logic INVERSION_SOURCE_STRAP_I, // source strap
   input wire logic [7:0] REG_ADDR_I, // address
   input wire logic [31:0] REG_WDATA_I, // write data
   input wire logic REG_WR_I, // write strobe
   input wire logic REG_RD_I, // read strobe
   input wire logic [31:0] REG_RDATA_O, // read data
   input wire mld_pkg::mld_addr_t SCAN_ROW_I, // scanned row
   input wire mld_pkg::mld_row_t SCAN_DATA_O, // shown row
   input wire logic COM_POLARITY_O // polarity
);
   // ********************************************************
   // assertions
   // ********************************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // status read, and the quiet span of each of the two sources
   sequence s_rd_st;
      REG_RD_I && REG_ADDR_I == 8'h00;
   endsequence
   sequence s_lo_src;
      !INVERSION_SOURCE_STRAP_I && !CHIP_SELECT_IN_I;
   endsequence
   sequence s_hi_src;
      INVERSION_SOURCE_STRAP_I && !$rose(EXTERNAL_INVERSION_TOGGLE_I);
   endsequence
   a_serial_src_hold: assert property (s_lo_src [*8] |=>
      $stable(COM_POLARITY_O)) else $error("polarity moved, no frame");
   a_toggle_flips: assert property (
      INVERSION_SOURCE_STRAP_I [*8] ##0 $rose(EXTERNAL_INVERSION_TOGGLE_I)
      |-> ##[1:5] $changed(COM_POLARITY_O))
      else $error("toggle edge did not flip polarity");
   a_toggle_quiet: assert property (s_hi_src [*7] |=>
      $stable(COM_POLARITY_O)) else $error("polarity moved, no toggle");
   a_off_white: assert property ((!DISPLAY_ON_INPUT_I) [*4] |=>
      SCAN_DATA_O == '1) else $error("display off not white");
   a_row_range: assert property (SCAN_ROW_I >= 8'ha8 |=>
      SCAN_DATA_O == '1) else $error("row beyond panel not white");
   a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0)
      else $error("read data outside read slot");
   a_strap_shown: assert property (
      $stable(INVERSION_SOURCE_STRAP_I) [*4] ##0 s_rd_st |=>
      REG_RDATA_O[0] == $past(INVERSION_SOURCE_STRAP_I))
      else $error("strap status wrong");
   a_display_on_input_shown: assert property (
      DISPLAY_ON_INPUT_I [*4] ##0 s_rd_st |=> REG_RDATA_O[1])
      else $error("display status wrong");
endmodule : mld_ctrl_checker

// *** bench/mld_host_model.sv ***
// host controller model driving the three-wire link
`timescale 1ns/1ns
module mld_host_model import mld_pkg::*; (
   output logic sclk_o, // link clock, still between frames
   output logic sdata_o, // link data
   output logic cs_o // frame select
);
   // ********************************************************
   // frame sender
   // ********************************************************
   // idle levels at time zero
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      cs_o = 1'b0;
   end
   // one bit per 160 ns, data set while the clock is low
   task automatic put(input logic b);
      sdata_o = b;
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
   endtask : put
   // mode byte, then one line when the update bit is set
   task automatic send(input logic [7:0] mode, input mld_addr_t a,
                       input mld_row_t p);
      #5 cs_o = 1'b1; // off the bench clock edge
      #400;
      for (int i = 0; i < 8; i++) put(mode[i]);
      if (mode[0]) begin
         for (int i = 0; i < 8; i++) put(a[i]);
         for (int i = 0; i < 144; i++) put(p[i]);
         for (int i = 0; i < 8; i++) put(1'b0);
      end
      #400 cs_o = 1'b0;
      sdata_o = ~sdata_o; // no pull on the released line
      #1200;
   endtask : send
endmodule : mld_host_model

// *** bench/mld_display_ctrl_bench.sv ***
// self-checking bench of the memory display control block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
   $display("CHECK FAILED %0t value mismatch", $time); end end
module mld_display_ctrl_bench import mld_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tog = 1'b0;
   logic display_on_input = 1'b0;
   logic strap = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   mld_addr_t row = 8'h00;
   mld_row_t sdat;
   logic pol, sclk, sdi, cs;
   logic sc_v = 1'b0;
   logic sc_p = 1'b0;
   logic rd_p = 1'b0;
   logic pol_e = 1'b0;
   logic [31:0] r_q[$], m_q[$];
   mld_row_t s_q[$];
   mld_row_t mem [168];
   int miscompares = 0;
   int checked = 0;
   // ********************************************************
   // clock, design and host
   // ********************************************************
   initial forever #10 clk = ~clk;
   mld_display_ctrl u_mld_display_ctrl (.CLK_I(clk), .RST_N_I(rst_n),
      .SERIAL_CLK_I(sclk), .SERIAL_DATA_I(sdi), .CHIP_SELECT_IN_I(cs),
      .EXTERNAL_INVERSION_TOGGLE_I(tog), .DISPLAY_ON_INPUT_I(display_on_input),
      .INVERSION_SOURCE_STRAP_I(strap), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .SCAN_ROW_I(row), .SCAN_DATA_O(sdat),
      .COM_POLARITY_O(pol));
   mld_host_model u_mld_host_model (.sclk_o(sclk), .sdata_o(sdi), .cs_o(cs));
   // ********************************************************
   // tasks
   // ********************************************************
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // expectation noted at launch, compared by the monitor
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      m_q.push_back(m);
      r_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_reg
   // every row plus two beyond the panel
   task automatic scan_all(input logic white);
      for (int r = 0; r < 170; r++) begin
         @(posedge clk);
         row <= 8'(r);
         sc_v <= 1'b1;
         s_q.push_back((white || r > 167) ? '1 : mem[r]);
      end
      @(posedge clk);
      sc_v <= 1'b0;
   endtask : scan_all
   task automatic toggle();
      @(posedge clk);
      tog <= 1'b1;
      repeat (8) @(posedge clk);
      tog <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : toggle
   task automatic results();
      if (miscompares == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // monitor: results land one cycle after their request
   always @(posedge clk) begin
      if (rd_p)
         `CHK(rdata & m_q.pop_front(), r_q.pop_front())
      if (sc_p)
         `CHK(sdat, s_q.pop_front())
      rd_p <= rd;
      sc_p <= sc_v;
   end
   // watchdog, far beyond the expected run
   initial begin
      #1500000;
      miscompares++;
      results();
   end
   // main sequence
   initial begin
      mld_addr_t a;
      mld_row_t p;
      void'($urandom(17));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(8'h04, 32'h1, 32'h1);
      rd_reg(8'h08, '1, 32'h0);
      u_mld_host_model.send(8'h04, 8'h00, '0);
      rd_reg(8'h00, 32'h8, 32'h8); // walker still busy
      for (int i = 0; i < 168; i++) mem[i] = '1;
      repeat (200) @(posedge clk);
      rd_reg(8'h00, 32'h8, 32'h0); // walker done
      scan_all(1'b1);
      display_on_input <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 8'h01 : (i == 1) ? 8'ha8 : 8'(1 + $urandom % 168);
         p = mld_row_t'({$urandom, $urandom, $urandom, $urandom, $urandom});
         mem[a - 1] = p;
         u_mld_host_model.send(8'h01, a, p);
      end
      scan_all(1'b0);
      u_mld_host_model.send(8'h01, 8'ha9, '0);
      rd_reg(8'h00, 32'h20, 32'h20);
      wr_reg(8'h00, 32'h20);
      rd_reg(8'h00, 32'h20, 32'h0);
      wr_reg(8'h04, 32'h0);
      u_mld_host_model.send(8'h01, 8'h05, '0); // link off, dropped
      wr_reg(8'h04, 32'h1);
      display_on_input <= 1'b0;
      repeat (4) @(posedge clk);
      scan_all(1'b1);
      display_on_input <= 1'b1;
      repeat (4) @(posedge clk);
      scan_all(1'b0);
      u_mld_host_model.send(8'h02, 8'h00, '0);
      toggle();
      rd_reg(8'h00, 32'h4, 32'h4);
      u_mld_host_model.send(8'h00, 8'h00, '0);
      rd_reg(8'h00, 32'h4, 32'h0);
      strap <= 1'b1;
      repeat (10) @(posedge clk);
      // a frame between toggles keeps them slower than the frame rate
      for (int i = 0; i < 3; i++) begin
         toggle();
         pol_e = ~pol_e;
         rd_reg(8'h00, 32'h7, {29'h0, pol_e, 2'b11});
         u_mld_host_model.send(8'h02, 8'h00, '0); // flag must be ignored
      end
      rd_reg(8'h00, 32'h4, {29'h0, pol_e, 2'b00});
      // let the monitor take the last read; nothing may be left over
      repeat (3) @(posedge clk);
      if (r_q.size() != 0 || s_q.size() != 0) miscompares++;
      results();
   end
endmodule : mld_display_ctrl_bench
bind mld_display_ctrl mld_ctrl_checker u_mld_ctrl_checker (.CLK_I(CLK_I),
   .RST_N_I(RST_N_I), .SERIAL_CLK_I(SERIAL_CLK_I),
   .SERIAL_DATA_I(SERIAL_DATA_I), .CHIP_SELECT_IN_I(CHIP_SELECT_IN_I),
   .EXTERNAL_INVERSION_TOGGLE_I(EXTERNAL_INVERSION_TOGGLE_I),
   .DISPLAY_ON_INPUT_I(DISPLAY_ON_INPUT_I),
   .INVERSION_SOURCE_STRAP_I(INVERSION_SOURCE_STRAP_I),
   .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
   .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .SCAN_ROW_I(SCAN_ROW_I),
   .SCAN_DATA_O(SCAN_DATA_O), .COM_POLARITY_O(COM_POLARITY_O));
